// ===== design/drive_port_pkg.sv
// Constants and types shared by the drive register port and the bus controller end.
// Assumes one core clock at 100 MHz and an asynchronous active-low reset in both ends.
// What this block does
// - Controller sets drive select, then register select.
// - Write: direction, then data, then request strobe.
// - Write strobe: addressed drive loads register, acknowledges.
// - Controller drops strobe after write acknowledge.
// - Strobe dropped after write: drive drops acknowledge.
// - Read: direction negated, no data, then strobe.
// - Read strobe: drive drives register word, acknowledges.
// - Controller captures word and drops strobe on one edge.
// - Strobe dropped after read: drive drops acknowledge.
// - Only the addressed drive drives data, acknowledge.
// - Ten registers all readable, some writable.
package drive_port_pkg;
    localparam int unsigned DATA_W     = 16;
    localparam int unsigned DRV_SEL_W  = 3;
    localparam int unsigned REG_SEL_W  = 5;
    localparam int unsigned NUM_REGS   = 10;
    // Registers that accept writes: 0, 3, 4, 5, 9
    localparam logic [NUM_REGS-1:0] WRITABLE_MASK = 10'h239;
    localparam logic [DATA_W-1:0]   REG_RESET     = 16'h0000;
    // Cycles the controller lets drive select settle before register select, and register select before the strobe (data gets one)
    localparam logic [1:0]          SETUP_CYCLES  = 2'h2;

    typedef logic [DATA_W-1:0]    word_t;
    typedef logic [DRV_SEL_W-1:0] drv_sel_t;
    typedef logic [REG_SEL_W-1:0] reg_sel_t;
endpackage

// ===== design/drive_ctl_bus_if.sv
// Shared control bus between one bus controller and one drive.
// The interface itself resolves the data and acknowledge wires from the enables.
`timescale 1ns/1ps
interface drive_ctl_bus_if;
    import drive_port_pkg::*;
    drv_sel_t drive_sel;
    reg_sel_t reg_sel;
    logic     direction_to_drive;
    logic     request_strobe;
    word_t    ctl_from_ctrl;
    logic     ctl_from_ctrl_oe;
    word_t    ctl_from_drive;
    logic     ctl_from_drive_oe;
    logic     handshake_ack;
    logic     handshake_ack_oe;
    // Resolved wire levels
    word_t    ctl_line;
    logic     ack_line;

    assign ctl_line = ctl_from_drive_oe ? ctl_from_drive :
                      (ctl_from_ctrl_oe ? ctl_from_ctrl : 16'h0000);
    assign ack_line = handshake_ack_oe & handshake_ack;

    modport controller (
        output drive_sel, reg_sel, direction_to_drive, request_strobe,
        output ctl_from_ctrl, ctl_from_ctrl_oe,
        input  ctl_line, ack_line
    );
    modport drive (
        input  drive_sel, reg_sel, direction_to_drive, request_strobe, ctl_line,
        output ctl_from_drive, ctl_from_drive_oe, handshake_ack, handshake_ack_oe
    );
endinterface

// ===== design/drive_reg_port.sv
// Drive end: decodes its select code and serves ten registers by full handshake.
// Assumes bus inputs come from another domain; strobe and direction are synchronised.
`timescale 1ns/1ps
module drive_reg_port (
    input  wire logic                     core_clk,
    input  wire logic                     arst_n,
    drive_ctl_bus_if.drive                bus,
    input  wire drive_port_pkg::drv_sel_t my_drive_sel,
    input  wire drive_port_pkg::word_t    status_in [drive_port_pkg::NUM_REGS],
    output logic [drive_port_pkg::NUM_REGS-1:0] reg_wr_pulse,
    output drive_port_pkg::word_t         reg_wr_data,
    output drive_port_pkg::word_t         reg_value [drive_port_pkg::NUM_REGS]
);
    import drive_port_pkg::*;

    typedef enum logic [1:0] {
        D_IDLE = 2'b00,
        D_ACK  = 2'b01
    } dstate_e;

    typedef struct packed {
        logic [1:0]            strb_sync;
        logic [1:0]            dir_sync;
        dstate_e               st;
        logic                  drive_data;
        word_t                 rd_word;
        logic [NUM_REGS-1:0]   wr_pulse;
        word_t                 wr_data;
        word_t [NUM_REGS-1:0]  regs;
    } dstate_s;

    dstate_s s_q;
    dstate_s s_d;
    logic    addressed;
    logic    reg_ok;
    int unsigned idx;

    assign addressed = (bus.drive_sel == my_drive_sel);
    assign idx       = 32'(bus.reg_sel);
    assign reg_ok    = (bus.reg_sel < REG_SEL_W'(NUM_REGS));

    // Next-state: handshake and register load
    always_comb begin
        s_d           = s_q;
        s_d.strb_sync = {s_q.strb_sync[0], bus.request_strobe};
        s_d.dir_sync  = {s_q.dir_sync[0], bus.direction_to_drive};
        s_d.wr_pulse  = '0;
        case (s_q.st)
            D_IDLE: begin
                if (s_q.strb_sync[1] && addressed) begin
                    s_d.st = D_ACK;
                    if (s_q.dir_sync[1]) begin
                        if (reg_ok && WRITABLE_MASK[idx]) begin
                            s_d.regs[idx]     = bus.ctl_line;
                            s_d.wr_pulse[idx] = 1'b1;
                            s_d.wr_data       = bus.ctl_line;
                        end
                    end else begin
                        s_d.drive_data = 1'b1;
                        s_d.rd_word    = !reg_ok ? 16'h0000 :
                                         (WRITABLE_MASK[idx] ? s_q.regs[idx] : status_in[idx]);
                    end
                end
            end
            D_ACK: begin
                if (!s_q.strb_sync[1]) begin
                    s_d.st         = D_IDLE;
                    s_d.drive_data = 1'b0;
                end
            end
            default: s_d.st = D_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '{strb_sync: 2'h0, dir_sync: 2'h0, st: D_IDLE, drive_data: 1'b0,
                     rd_word: REG_RESET, wr_pulse: '0, wr_data: REG_RESET,
                     regs: {NUM_REGS{REG_RESET}}};
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs: data comes on the acknowledge edge, so it is valid when acknowledge rises
    assign bus.ctl_from_drive    = s_q.rd_word;
    assign bus.ctl_from_drive_oe = s_q.drive_data;
    assign bus.handshake_ack     = (s_q.st == D_ACK);
    assign bus.handshake_ack_oe  = (s_q.st == D_ACK);
    assign reg_wr_pulse          = s_q.wr_pulse;
    assign reg_wr_data           = s_q.wr_data;

    // Register contents presented to the user side
    generate
        for (genvar g = 0; g < NUM_REGS; g++) begin : g_val
            assign reg_value[g] = WRITABLE_MASK[g] ? s_q.regs[g] : status_in[g];
        end
    endgenerate
endmodule

// ===== design/bus_controller.sv
// Controller end: runs one register read or write per request by full handshake.
// Assumes the acknowledge and data lines come from a drive in another domain.
`timescale 1ns/1ps
module bus_controller (
    input  wire logic                     core_clk,
    input  wire logic                     arst_n,
    drive_ctl_bus_if.controller           bus,
    input  wire logic                     req_valid,
    output logic                          req_ready,
    input  wire logic                     req_write,
    input  wire drive_port_pkg::drv_sel_t req_drive,
    input  wire drive_port_pkg::reg_sel_t req_reg,
    input  wire drive_port_pkg::word_t    req_wdata,
    output logic                          done,
    output drive_port_pkg::word_t         rdata
);
    import drive_port_pkg::*;

    typedef enum logic [2:0] {
        C_IDLE  = 3'b000,
        C_SEL   = 3'b001,
        C_SETUP = 3'b010,
        C_STRB  = 3'b011,
        C_DROP  = 3'b100
    } cstate_e;

    typedef struct packed {
        logic [1:0] ack_sync;
        cstate_e    st;
        logic [1:0] cnt;
        logic       wr;
        drv_sel_t   drv;
        reg_sel_t   rsel;
        logic       dir;
        logic       strb;
        word_t      wdata;
        logic       data_oe;
        word_t      rdata;
        logic       done;
    } cstate_s;

    cstate_s s_q;
    cstate_s s_d;

    // Sequencer: select, direction and data settle before the strobe
    always_comb begin
        s_d          = s_q;
        s_d.ack_sync = {s_q.ack_sync[0], bus.ack_line};
        s_d.done     = 1'b0;
        case (s_q.st)
            C_IDLE: begin
                if (req_valid) begin
                    s_d.st    = C_SEL;
                    s_d.wr    = req_write;
                    s_d.drv   = req_drive;
                    s_d.wdata = req_wdata;
                    s_d.cnt   = SETUP_CYCLES;
                end
            end
            C_SEL: begin
                s_d.cnt = s_q.cnt - 2'h1;
                if (s_q.cnt == 2'h1) begin
                    s_d.rsel = req_reg;
                    s_d.dir  = s_q.wr;
                    s_d.cnt  = SETUP_CYCLES;
                    s_d.st   = C_SETUP;
                end
            end
            C_SETUP: begin
                s_d.cnt     = s_q.cnt - 2'h1;
                s_d.data_oe = s_q.wr;
                if (s_q.cnt == 2'h1) begin
                    s_d.st   = C_STRB;
                    s_d.strb = 1'b1;
                end
            end
            C_STRB: begin
                if (s_q.ack_sync[1]) begin
                    if (!s_q.wr) begin
                        s_d.rdata = bus.ctl_line;
                    end
                    s_d.strb = 1'b0;
                    s_d.st   = C_DROP;
                end
            end
            C_DROP: begin
                if (!s_q.ack_sync[1]) begin
                    s_d.data_oe = 1'b0;
                    s_d.dir     = 1'b0;
                    s_d.done    = 1'b1;
                    s_d.st      = C_IDLE;
                end
            end
            default: s_d.st = C_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '{ack_sync: 2'h0, st: C_IDLE, cnt: 2'h0, wr: 1'b0, drv: '0, rsel: '0,
                     dir: 1'b0, strb: 1'b0, wdata: REG_RESET, data_oe: 1'b0,
                     rdata: REG_RESET, done: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.drive_sel          = s_q.drv;
    assign bus.reg_sel            = s_q.rsel;
    assign bus.direction_to_drive = s_q.dir;
    assign bus.request_strobe     = s_q.strb;
    assign bus.ctl_from_ctrl      = s_q.wdata;
    assign bus.ctl_from_ctrl_oe   = s_q.data_oe;
    assign req_ready              = (s_q.st == C_IDLE);
    assign done                   = s_q.done;
    assign rdata                  = s_q.rdata;
endmodule

// ===== testbench/drive_port_props.sv
// Checker for the control bus shared by the controller end and the drive end.
// Assumes instantiation beside the bus, one clock domain, async active-low reset.
`timescale 1ns/1ps
module drive_port_props (
    input wire logic                     core_clk,
    input wire logic                     arst_n,
    input wire drive_port_pkg::drv_sel_t my_drive_sel,
    input wire drive_port_pkg::drv_sel_t drive_sel,
    input wire drive_port_pkg::reg_sel_t reg_sel,
    input wire logic                     direction_to_drive,
    input wire logic                     request_strobe,
    input wire logic                     ctl_from_ctrl_oe,
    input wire logic                     ctl_from_drive_oe,
    input wire logic                     handshake_ack_oe,
    input wire logic                     ack_line
);
    import drive_port_pkg::*;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    // Handshake order on both sides
    sel_settled_a: assert property (
        request_strobe |-> $stable(drive_sel) && $stable(reg_sel))
        else $error("selects moved under strobe");
    write_setup_a: assert property (
        $rose(request_strobe) && direction_to_drive |->
        ctl_from_ctrl_oe && $past(ctl_from_ctrl_oe) && $past(direction_to_drive, 2))
        else $error("write strobe before data setup");
    read_no_data_a: assert property (
        request_strobe && !direction_to_drive |-> !ctl_from_ctrl_oe)
        else $error("controller drives data in read");
    ack_after_sync_a: assert property (
        $rose(ack_line) |-> request_strobe && $past(request_strobe))
        else $error("ack without synchronised strobe");
    ack_answer_a: assert property (
        $rose(request_strobe) && drive_sel == my_drive_sel |-> ##[1:8] ack_line)
        else $error("addressed drive never acknowledged");
    ack_hold_a: assert property (
        ack_line && request_strobe |=> ack_line)
        else $error("ack dropped under strobe");
    ack_release_a: assert property (
        $fell(request_strobe) |-> ##[1:6] !ack_line)
        else $error("ack held after strobe drop");
    strobe_wait_a: assert property (
        request_strobe && !ack_line |=> request_strobe)
        else $error("strobe dropped before ack");
    strobe_drop_a: assert property (
        $rose(ack_line) |-> ##[1:4] !request_strobe)
        else $error("strobe kept after ack");
    read_gate_a: assert property (
        ack_line && request_strobe && !direction_to_drive |-> ctl_from_drive_oe)
        else $error("read ack without data");
    other_quiet_a: assert property (
        drive_sel != my_drive_sel |-> !handshake_ack_oe && !ctl_from_drive_oe)
        else $error("unaddressed drive drives bus");

    // Main scenarios
    cover property ($rose(ack_line) && direction_to_drive);
    cover property ($rose(ack_line) && !direction_to_drive);
    cover property ($rose(request_strobe) && drive_sel != my_drive_sel);
endmodule

// ===== testbench/test_drive_register_access_port.sv
// Bench joining the controller end and the drive end across one bus.
// Assumes the package constants; expectations follow the write mask.
`timescale 1ns/1ps
module test_drive_register_access_port;
    import drive_port_pkg::*;
    typedef struct {logic w; reg_sel_t r; word_t d; word_t e;} row_s;
    logic         core_clk;
    logic         arst_n;
    logic         req_valid;
    logic         req_ready;
    logic         req_write;
    drv_sel_t     req_drive;
    reg_sel_t     req_reg;
    word_t        req_wdata;
    logic         done;
    word_t        rdata;
    drv_sel_t     my_drive_sel;
    word_t        status_in [NUM_REGS];
    word_t        reg_value [NUM_REGS];
    logic [NUM_REGS-1:0] wr_pulse;
    word_t        wr_data;
    logic [NUM_REGS-1:0] wr_mask = '0;
    int           n_pulse = 0;
    row_s         rows [20];
    int           n_errors;
    int           cmp_count;

    drive_ctl_bus_if i_drive_ctl_bus_if ();
    bus_controller i_bus_controller (.core_clk(core_clk), .arst_n(arst_n),
        .bus(i_drive_ctl_bus_if), .req_valid(req_valid), .req_ready(req_ready),
        .req_write(req_write), .req_drive(req_drive), .req_reg(req_reg),
        .req_wdata(req_wdata), .done(done), .rdata(rdata));
    drive_reg_port i_drive_reg_port (.core_clk(core_clk), .arst_n(arst_n),
        .bus(i_drive_ctl_bus_if), .my_drive_sel(my_drive_sel), .status_in(status_in),
        .reg_wr_pulse(wr_pulse), .reg_wr_data(wr_data), .reg_value(reg_value));
    drive_port_props i_props (.core_clk(core_clk), .arst_n(arst_n),
        .my_drive_sel(my_drive_sel), .drive_sel(i_drive_ctl_bus_if.drive_sel),
        .reg_sel(i_drive_ctl_bus_if.reg_sel),
        .direction_to_drive(i_drive_ctl_bus_if.direction_to_drive),
        .request_strobe(i_drive_ctl_bus_if.request_strobe),
        .ctl_from_ctrl_oe(i_drive_ctl_bus_if.ctl_from_ctrl_oe),
        .ctl_from_drive_oe(i_drive_ctl_bus_if.ctl_from_drive_oe),
        .handshake_ack_oe(i_drive_ctl_bus_if.handshake_ack_oe),
        .ack_line(i_drive_ctl_bus_if.ack_line));

    // Clock of 10 ns
    always #5 core_clk = ~core_clk;

    // Collects write pulses so their positions and lengths can be checked
    always @(posedge core_clk) begin
        if (arst_n) begin
            wr_mask <= wr_mask | wr_pulse;
            if (wr_pulse != '0) n_pulse <= n_pulse + 1;
        end
    end

    task automatic close_out();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input word_t seen, input word_t exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One transfer: accept edge, then bounded wait for done
    task automatic xfer(input logic w, input reg_sel_t r, input word_t d, input word_t e,
                        input logic ed);
        int n;
        n = 0;
        @(posedge core_clk);
        req_valid <= 1'b1;
        req_write <= w;
        req_drive <= 3'h2;
        req_reg   <= r;
        req_wdata <= d;
        @(posedge core_clk);
        req_valid <= 1'b0;
        // Read at the edge: done still shows what the previous edge launched
        while (done !== 1'b1 && n < 40) begin
            @(posedge core_clk);
            n++;
        end
        check(word_t'(n < 40), word_t'(ed));
        if (!w && ed) check(rdata, e);
    endtask

    // Watchdog
    initial begin
        #50000;
        n_errors++;
        close_out();
    end

    // Table of ordinary cases, then awkward ones
    initial begin
        core_clk = 1'b0;
        arst_n = 1'b0;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_drive = 3'h0;
        req_reg = 5'h00;
        req_wdata = 16'h0000;
        my_drive_sel = 3'h2;
        n_errors = 0;
        cmp_count = 0;
        for (int i = 0; i < NUM_REGS; i++) status_in[i] = 16'h3c00 + 16'(i);
        for (int i = 0; i < 20; i++) begin
            rows[i].w = (i < 10);
            rows[i].r = 5'(i % 10);
            rows[i].d = 16'ha5c0 + 16'(i % 10);
            rows[i].e = WRITABLE_MASK[i % 10] ? rows[i].d : status_in[i % 10];
        end
        repeat (6) @(posedge core_clk);
        check({14'h0000, req_ready, done}, 16'h0002);
        arst_n <= 1'b1;
        for (int i = 0; i < 20; i++) begin
            xfer(rows[i].w, rows[i].r, rows[i].d, rows[i].e, 1'b1);
            if (rows[i].w) check(reg_value[rows[i].r], rows[i].e);
            if (rows[i].w && WRITABLE_MASK[rows[i].r]) check(wr_data, rows[i].d);
        end
        xfer(1'b0, 5'h0a, 16'h0000, 16'h0000, 1'b1);
        xfer(1'b0, 5'h1f, 16'h0000, 16'h0000, 1'b1);
        xfer(1'b1, 5'h01, 16'hffff, 16'h0000, 1'b1);
        xfer(1'b0, 5'h01, 16'h0000, status_in[1], 1'b1);
        check(word_t'(wr_mask), word_t'(WRITABLE_MASK));
        check(word_t'(n_pulse), word_t'($countones(WRITABLE_MASK)));
        @(posedge core_clk);
        my_drive_sel <= 3'h3;
        xfer(1'b0, 5'h00, 16'h0000, 16'h0000, 1'b0);
        check({14'h0000, i_drive_ctl_bus_if.ack_line, i_drive_ctl_bus_if.ctl_from_drive_oe},
              16'h0000);
        // Second reset recovers the stalled controller
        arst_n <= 1'b0;
        repeat (6) @(posedge core_clk);
        check(reg_value[0], REG_RESET);
        arst_n <= 1'b1;
        my_drive_sel <= 3'h2;
        xfer(1'b0, 5'h00, 16'h0000, REG_RESET, 1'b1);
        close_out();
    end
endmodule
